/* src/lp4i_init_top.sv */
// power-up initialization tracker of the memory device with apb status
//
// Overview of operation
// - latency and recovery fields reset to 000
// - set point, inversion, terminations reset cleared
// - both references reset to range 1, 001101
// - drivers off while reset pin low
// - latch after 1 us applies calibration
// - mode 2 bit 7 sets wr_level, which nothing in the tracker uses
// - training buffer leaves array untouched
// - ready accepts any command afterwards
// - one reset pin resets all channels
// - gate high enables a channel's drivers
`timescale 1ns/1ps
module lp4i_init_top #(
   parameter int CHANNELS = 2
) (
   input  wire logic                pclk,
   input  wire logic                presetn,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [11:0]         paddr,
   input  wire logic [31:0]         pwdata,
   output logic                     pready,
   output logic                     pslverr,
   output logic [31:0]              prdata,
   input  wire logic                dev_reset_n,
   input  wire logic [CHANNELS-1:0] clock_gate,
   input  wire logic [CHANNELS-1:0] chip_select,
   input  wire logic                cmd_valid,
   input  wire logic [2:0]          cmd_code,
   input  wire logic [5:0]          cmd_addr,
   input  wire logic [7:0]          cmd_data,
   output logic [CHANNELS-1:0]      drive_enable,
   output logic                     rd_valid,
   output logic [7:0]               rd_data,
   output logic                     cal_applied
);

   // ==========================================================
   // mode registers
   lp4i_mr_if mr ();

   lp4i_mode_regs u_regs (
      .pclk    (pclk),
      .presetn (presetn),
      .mr      (mr)
   );

   // ==========================================================
   // sequence state
   localparam int CW = lp4i_pkg::CAL_CNT_W;
   localparam logic [CW-1:0] CAL_LAST = CW'(lp4i_pkg::IMPEDANCE_CAL_CYCLES - 1);

   lp4i_pkg::lp4i_state_t state_reg;
   lp4i_pkg::lp4i_state_t state_next;
   logic [CW-1:0]         cal_cnt_reg;
   logic [CW-1:0]         cal_cnt_next;
   logic                  cal_applied_reg;
   logic                  cal_applied_next;
   logic [7:0]            err_reg;
   logic [7:0]            err_next;
   logic                  cmd_take;

   // ==========================================================
   // helpers
   function automatic logic is_mapped(input logic [11:0] addr);
      is_mapped = addr == lp4i_pkg::REG_STATUS  ||
                  addr == lp4i_pkg::REG_CONTROL ||
                  addr == lp4i_pkg::REG_MR_LOW  ||
                  addr == lp4i_pkg::REG_MR_HIGH ||
                  addr == lp4i_pkg::REG_ERRORS;
   endfunction

   function automatic logic cmd_is(input logic       take,
                                   input logic [2:0] code,
                                   input logic [2:0] want);
      cmd_is = take && code == want;
   endfunction

   // a command counts only on a channel whose gate is open and selected
   assign cmd_take = cmd_valid && dev_reset_n && |(chip_select & clock_gate);

   always_comb begin
      state_next       = state_reg;
      cal_cnt_next     = cal_cnt_reg;
      cal_applied_next = cal_applied_reg;
      err_next         = err_reg;
      if (!dev_reset_n) begin
         // one pin clears every channel at once
         state_next       = lp4i_pkg::ST_RESET;
         cal_cnt_next     = '0;
         cal_applied_next = 1'b0;
      end else begin
         case (state_reg)
            lp4i_pkg::ST_RESET: begin
               state_next = lp4i_pkg::ST_GATE_WAIT;
            end
            lp4i_pkg::ST_GATE_WAIT: begin
               if (|clock_gate) begin
                  state_next = lp4i_pkg::ST_BOOT;
               end
            end
            lp4i_pkg::ST_BOOT: begin
               if (cmd_is(cmd_take, cmd_code, lp4i_pkg::CMD_CAL_START)) begin
                  state_next   = lp4i_pkg::ST_CAL_RUN;
                  cal_cnt_next = '0;
               end
            end
            lp4i_pkg::ST_CAL_RUN: begin
               if (cal_cnt_reg == CAL_LAST) begin
                  state_next = lp4i_pkg::ST_CAL_DONE;
               end else begin
                  cal_cnt_next = cal_cnt_reg + 1'b1;
               end
            end
            lp4i_pkg::ST_CAL_DONE: begin
               state_next = lp4i_pkg::ST_CAL_DONE;
            end
            lp4i_pkg::ST_TRAIN: begin
               if (cmd_is(cmd_take, cmd_code, lp4i_pkg::CMD_MP_BUF_READ)) begin
                  state_next = lp4i_pkg::ST_READY;
               end
            end
            lp4i_pkg::ST_READY: begin
               // every command keeps being served here
               state_next = lp4i_pkg::ST_READY;
            end
            default: begin
               state_next = lp4i_pkg::ST_RESET;
            end
         endcase
         if (cmd_is(cmd_take, cmd_code, lp4i_pkg::CMD_CAL_LATCH)) begin
            // latch always applies; an early one is only counted, not refused
            cal_applied_next = 1'b1;
            if (state_reg == lp4i_pkg::ST_CAL_RUN && err_reg != 8'hff) begin
               err_next = err_reg + 8'h01;
            end
            if (state_reg == lp4i_pkg::ST_CAL_RUN || state_reg == lp4i_pkg::ST_CAL_DONE) begin
               state_next = lp4i_pkg::ST_TRAIN;
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg       <= lp4i_pkg::ST_RESET;
         cal_cnt_reg     <= '0;
         cal_applied_reg <= 1'b0;
         err_reg         <= 8'h00;
      end else begin
         state_reg       <= state_next;
         cal_cnt_reg     <= cal_cnt_next;
         cal_applied_reg <= cal_applied_next;
         err_reg         <= err_next;
      end
   end

   // ==========================================================
   // command data path
   logic [CHANNELS-1:0] drive_reg;
   logic [CHANNELS-1:0] drive_next;
   logic                rd_valid_reg;
   logic                rd_valid_next;
   logic [7:0]          rd_data_reg;
   logic [7:0]          rd_data_next;
   logic [7:0]          train_reg  [lp4i_pkg::TRAIN_DEPTH];
   logic [7:0]          train_next [lp4i_pkg::TRAIN_DEPTH];

   always_comb begin
      // drivers follow the gate, and stay off while the pin is low
      drive_next    = clock_gate & {CHANNELS{dev_reset_n}};
      rd_valid_next = 1'b0;
      rd_data_next  = rd_data_reg;
      train_next    = train_reg;
      if (!dev_reset_n) begin
         rd_data_next = 8'h00;
      end else if (cmd_is(cmd_take, cmd_code, lp4i_pkg::CMD_MODE_REG_READ)) begin
         rd_valid_next = 1'b1;
         rd_data_next  = mr.rd_data;
      end else if (cmd_is(cmd_take, cmd_code, lp4i_pkg::CMD_MP_READ_CAL)) begin
         rd_valid_next = 1'b1;
         rd_data_next  = lp4i_pkg::READ_CAL_BASE;
      end else if (cmd_is(cmd_take, cmd_code, lp4i_pkg::CMD_MP_BUF_READ)) begin
         rd_valid_next = 1'b1;
         rd_data_next  = train_reg[cmd_addr[1:0]];
      end
      // the training buffer is separate storage, so the array is never touched
      if (cmd_is(cmd_take, cmd_code, lp4i_pkg::CMD_MP_BUF_WRITE)) begin
         train_next[cmd_addr[1:0]] = cmd_data;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         drive_reg    <= '0;
         rd_valid_reg <= 1'b0;
         rd_data_reg  <= 8'h00;
         train_reg    <= '{default: 8'h00};
      end else begin
         drive_reg    <= drive_next;
         rd_valid_reg <= rd_valid_next;
         rd_data_reg  <= rd_data_next;
         train_reg    <= train_next;
      end
   end

   // ==========================================================
   // apb status port
   logic [31:0] prdata_reg;
   logic [31:0] prdata_next;
   logic [5:0]  mr_sel_reg;
   logic [5:0]  mr_sel_next;
   logic        soft_reset_reg;
   logic        soft_reset_next;
   logic        apb_setup;
   logic        apb_write;

   // no wait states: read data is taken in the setup cycle
   assign apb_setup = psel && !penable;
   assign apb_write = psel && penable && pwrite && is_mapped(paddr);
   assign pready    = psel && penable;
   assign pslverr   = psel && penable && !is_mapped(paddr);

   always_comb begin
      prdata_next     = prdata_reg;
      mr_sel_next     = mr_sel_reg;
      soft_reset_next = 1'b0;
      if (apb_setup && !pwrite) begin
         case (paddr)
            lp4i_pkg::REG_STATUS:  prdata_next = {29'h0, state_reg};
            lp4i_pkg::REG_CONTROL: prdata_next = 32'h0;
            lp4i_pkg::REG_MR_LOW:  prdata_next = {26'h0, mr_sel_reg};
            lp4i_pkg::REG_MR_HIGH: prdata_next = {24'h0, mr.rd_data};
            lp4i_pkg::REG_ERRORS:  prdata_next = {24'h0, err_reg};
            default:               prdata_next = 32'h0;
         endcase
      end
      if (apb_write && paddr == lp4i_pkg::REG_MR_LOW) begin
         mr_sel_next = pwdata[5:0];
      end
      if (apb_write && paddr == lp4i_pkg::REG_CONTROL) begin
         soft_reset_next = pwdata[0] == lp4i_pkg::CONTROL_RESET;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg     <= 32'h0;
         mr_sel_reg     <= 6'h00;
         soft_reset_reg <= 1'b0;
      end else begin
         prdata_reg     <= prdata_next;
         mr_sel_reg     <= mr_sel_next;
         soft_reset_reg <= soft_reset_next;
      end
   end

   // ==========================================================
   // mode register access and outputs
   // any valid command, not only a read, wins the shared read port over the status view
   assign mr.dev_reset = !dev_reset_n || soft_reset_reg;
   assign mr.wr_en     = cmd_is(cmd_take, cmd_code, lp4i_pkg::CMD_MODE_REG_WRITE);
   assign mr.wr_addr   = cmd_addr;
   assign mr.wr_data   = cmd_data;
   assign mr.rd_addr   = cmd_valid ? cmd_addr : mr_sel_reg;

   assign prdata       = prdata_reg;
   assign drive_enable = drive_reg;
   assign rd_valid     = rd_valid_reg;
   assign rd_data      = rd_data_reg;
   assign cal_applied  = cal_applied_reg;

endmodule

/* src/lp4i_pkg.sv */
// constants, command codes and states shared by the init sequencer files
package lp4i_pkg;

   // ==========================================================
   // clock and timing
   localparam int CLK_PERIOD_PS          = 25000;
   localparam int IMPEDANCE_CAL_TIME_US  = 1;
   localparam int IMPEDANCE_CAL_CYCLES   =
      (IMPEDANCE_CAL_TIME_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int CAL_CNT_W              = 8;

   // ==========================================================
   // command codes on the command inputs
   localparam logic [2:0] CMD_MODE_REG_READ  = 3'h0;
   localparam logic [2:0] CMD_MODE_REG_WRITE = 3'h1;
   localparam logic [2:0] CMD_CAL_START      = 3'h2;
   localparam logic [2:0] CMD_CAL_LATCH      = 3'h3;
   localparam logic [2:0] CMD_MP_READ_CAL    = 3'h4;
   localparam logic [2:0] CMD_MP_BUF_WRITE   = 3'h5;
   localparam logic [2:0] CMD_MP_BUF_READ    = 3'h6;

   // ==========================================================
   // mode register indices, field positions and reset values
   localparam int         MR_ADDR_W      = 6;
   localparam int         MR_DEPTH       = 64;
   localparam logic [5:0] MR1_IDX        = 6'h01;
   localparam logic [5:0] MR2_IDX        = 6'h02;
   localparam logic [5:0] MR3_IDX        = 6'h03;
   localparam logic [5:0] MR11_IDX       = 6'h0b;
   localparam logic [5:0] MR12_IDX       = 6'h0c;
   localparam logic [5:0] MR13_IDX       = 6'h0d;
   localparam logic [5:0] MR14_IDX       = 6'h0e;
   localparam logic [5:0] MR15_IDX       = 6'h0f;
   localparam int         MR2_WR_LEVEL_BIT = 7;
   localparam int         MR13_CBT_BIT     = 0;
   localparam logic [7:0] MR1_DEFAULT    = 8'h00;  // write_recovery code 000
   localparam logic [7:0] MR2_DEFAULT    = 8'h00;  // set 0, write/read latency 000
   localparam logic [7:0] MR3_DEFAULT    = 8'h00;  // bus_inversion_enables off
   localparam logic [7:0] MR11_DEFAULT   = 8'h00;  // both terminations off
   localparam logic [7:0] MR12_DEFAULT   = 8'h4d;  // range 1, code 001101
   localparam logic [7:0] MR13_DEFAULT   = 8'h00;  // frequency_set_point_select 00
   localparam logic [7:0] MR14_DEFAULT   = 8'h4d;  // range 1, code 001101

   // ==========================================================
   // training buffer and apb map
   localparam int          TRAIN_DEPTH    = 4;
   localparam logic [7:0]  READ_CAL_BASE  = 8'h5a;
   localparam logic [11:0] REG_STATUS     = 12'h000;
   localparam logic [11:0] REG_CONTROL    = 12'h004;
   localparam logic [11:0] REG_MR_LOW     = 12'h008;
   localparam logic [11:0] REG_MR_HIGH    = 12'h00c;
   localparam logic [11:0] REG_ERRORS     = 12'h010;
   localparam logic [0:0]  CONTROL_RESET  = 1'h1;

   typedef enum logic [2:0] {
      ST_RESET, ST_GATE_WAIT, ST_BOOT, ST_CAL_RUN, ST_CAL_DONE, ST_TRAIN, ST_READY
   } lp4i_state_t;

endpackage

/* src/lp4i_mr_if.sv */
// carrier between the sequencer and its mode register file
`timescale 1ns/1ps
interface lp4i_mr_if;
   logic       dev_reset;
   logic       wr_en;
   logic [5:0] wr_addr;
   logic [7:0] wr_data;
   logic [5:0] rd_addr;
   logic [7:0] rd_data;
   logic       wr_level;
   logic       cbt_mode;
   modport seq  (output dev_reset, wr_en, wr_addr, wr_data, rd_addr,
                 input  rd_data, wr_level, cbt_mode);
   modport regs (input  dev_reset, wr_en, wr_addr, wr_data, rd_addr,
                 output rd_data, wr_level, cbt_mode);
endinterface

/* src/lp4i_mode_regs.sv */
// mode register array with reset defaults
`timescale 1ns/1ps
module lp4i_mode_regs (
   input  wire logic pclk,
   input  wire logic presetn,
   lp4i_mr_if.regs   mr
);

   // ==========================================================
   // defaults
   function automatic logic [7:0] default_of(input logic [5:0] idx);
      case (idx)
         lp4i_pkg::MR1_IDX:  default_of = lp4i_pkg::MR1_DEFAULT;
         lp4i_pkg::MR2_IDX:  default_of = lp4i_pkg::MR2_DEFAULT;
         lp4i_pkg::MR3_IDX:  default_of = lp4i_pkg::MR3_DEFAULT;
         lp4i_pkg::MR11_IDX: default_of = lp4i_pkg::MR11_DEFAULT;
         lp4i_pkg::MR12_IDX: default_of = lp4i_pkg::MR12_DEFAULT;
         lp4i_pkg::MR13_IDX: default_of = lp4i_pkg::MR13_DEFAULT;
         lp4i_pkg::MR14_IDX: default_of = lp4i_pkg::MR14_DEFAULT;
         default:            default_of = 8'h00;
      endcase
   endfunction

   // ==========================================================
   // storage
   logic [7:0] mr_reg  [lp4i_pkg::MR_DEPTH];
   logic [7:0] mr_next [lp4i_pkg::MR_DEPTH];

   always_comb begin
      for (int i = 0; i < lp4i_pkg::MR_DEPTH; i++) begin
         if (mr.dev_reset) begin
            mr_next[i] = default_of(6'(i));
         end else if (mr.wr_en && mr.wr_addr == 6'(i)) begin
            mr_next[i] = mr.wr_data;
         end else begin
            mr_next[i] = mr_reg[i];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < lp4i_pkg::MR_DEPTH; i++) begin
            mr_reg[i] <= default_of(6'(i));
         end
      end else begin
         for (int i = 0; i < lp4i_pkg::MR_DEPTH; i++) begin
            mr_reg[i] <= mr_next[i];
         end
      end
   end

   assign mr.rd_data  = mr_reg[mr.rd_addr];
   assign mr.wr_level = mr_reg[lp4i_pkg::MR2_IDX][lp4i_pkg::MR2_WR_LEVEL_BIT];
   assign mr.cbt_mode = mr_reg[lp4i_pkg::MR13_IDX][lp4i_pkg::MR13_CBT_BIT];

endmodule

/* tb/lp4i_init_monitor.sv */
// port checker for the init tracker
`timescale 1ns/1ps
module lp4i_init_monitor #(parameter int CHANNELS = 2) (
   input wire logic                pclk,
   input wire logic                presetn,
   input wire logic                dev_reset_n,
   input wire logic [CHANNELS-1:0] clock_gate,
   input wire logic                cmd_valid,
   input wire logic [2:0]          cmd_code,
   input wire logic [CHANNELS-1:0] drive_enable,
   input wire logic                rd_valid,
   input wire logic                cal_applied
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_rst_off: assert property (!dev_reset_n [*2] |-> drive_enable == '0)
      else $error("drive in reset");
   a_rst_cal: assert property (!dev_reset_n [*2] |-> !cal_applied)
      else $error("cal kept in reset");
   a_gate_a: assert property (!clock_gate[0] [*2] |-> !drive_enable[0])
      else $error("drive a gated");
   a_gate_b: assert property (!clock_gate[CHANNELS-1] [*2] |-> !drive_enable[CHANNELS-1])
      else $error("drive b gated");
   a_rd_ans: assert property (cmd_valid && cmd_code == lp4i_pkg::CMD_MODE_REG_READ
      |-> ##[0:4] rd_valid) else $error("read unanswered");
   a_latch_on: assert property (cmd_valid && cmd_code == lp4i_pkg::CMD_CAL_LATCH
      |-> ##[0:4] cal_applied) else $error("latch not applied");
   a_rd_quiet: assert property (rd_valid |-> dev_reset_n) else $error("read in reset");
   a_cal_cause: assert property ($rose(cal_applied) |-> dev_reset_n)
      else $error("cal in reset");
   c_cal: cover property ($rose(cal_applied));
   c_rd: cover property (rd_valid);
   c_warm: cover property ($fell(dev_reset_n));
endmodule
bind lp4i_init_top lp4i_init_monitor #(.CHANNELS(CHANNELS)) lp4i_init_monitor_i (.pclk,
   .presetn, .dev_reset_n, .clock_gate, .cmd_valid, .cmd_code, .drive_enable, .rd_valid,
   .cal_applied);

/* tb/lp4i_ctrl_model.sv */
// controller model driving reset, clock gates and commands
`timescale 1ns/1ps
module lp4i_ctrl_model #(parameter int GATE_WAIT = 80, parameter int ACCESS_WAIT = 80) (
   input  wire logic  pclk,
   output logic       dev_reset_n = 1'b0,
   output logic [1:0] clock_gate = '0,
   output logic [1:0] chip_select = '0,
   output logic       cmd_valid = 1'b0,
   output logic [2:0] cmd_code = '0,
   output logic [5:0] cmd_addr = '0,
   output logic [7:0] cmd_data = '0
);
   // gate wait scaled down to keep the run short
   task power_up(input int low);
      @(posedge pclk);
      dev_reset_n <= 1'b0;
      clock_gate <= '0;
      repeat (low) @(posedge pclk);
      dev_reset_n <= 1'b1;
      repeat (GATE_WAIT) @(posedge pclk);
      clock_gate <= '1;
      repeat (ACCESS_WAIT) @(posedge pclk);
   endtask
   task issue(input logic [2:0] c, input logic [5:0] a, input logic [7:0] d);
      @(posedge pclk);
      cmd_valid <= 1'b1;
      chip_select <= '1;
      cmd_code <= c;
      cmd_addr <= a;
      cmd_data <= d;
      @(posedge pclk);
      cmd_valid <= 1'b0;
      chip_select <= '0;
      cmd_addr <= ~a; // released lines flip so stale values cannot pass
      cmd_data <= ~d;
   endtask
endmodule

/* tb/lp4i_init_top_bench.sv */
// self-checking bench for the init tracker
`timescale 1ns/1ps
module lp4i_init_top_bench;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, q;
   logic [1:0]  chip_select, clock_gate, drive_enable;
   logic        dev_reset_n, cmd_valid, pready, pslverr, rd_valid, cal_applied, e;
   logic [2:0]  cmd_code;
   logic [5:0]  cmd_addr, ma[7] = '{6'h01, 6'h02, 6'h03, 6'h0b, 6'h0c, 6'h0d, 6'h0e};
   logic [7:0]  cmd_data, rd_data, md[7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h4d, 8'h00, 8'h4d};
   int          fail_count = 0, cmp_count = 0;
   initial forever #12.5 pclk = ~pclk;
   lp4i_init_top #(.CHANNELS(2)) lp4i_init_top_i (.pclk, .presetn, .psel, .penable, .pwrite,
      .paddr, .pwdata, .pready, .pslverr, .prdata, .dev_reset_n, .clock_gate, .chip_select,
      .cmd_valid, .cmd_code, .cmd_addr, .cmd_data, .drive_enable, .rd_valid, .rd_data,
      .cal_applied);
   lp4i_ctrl_model ctl_i (.pclk, .dev_reset_n, .clock_gate, .chip_select, .cmd_valid,
      .cmd_code, .cmd_addr, .cmd_data);
   task chk(input string n, input logic [31:0] x, input logic [31:0] g);
      cmp_count++;
      if (g !== x) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", n, x, g);
      end
   endtask
   task give_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task rd_chk(input logic [2:0] c, input logic [5:0] a, input logic [7:0] x);
      ctl_i.issue(c, a, 8'h00);
      @(negedge pclk);
      for (int n = 0; n < 20 && rd_valid !== 1'b1; n++) @(negedge pclk);
      chk("rd_valid", 1, {31'h0, rd_valid});
      chk("read data", {24'h0, x}, {24'h0, rd_data});
   endtask
   // apb master: waits for pready, no fixed latency assumed
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk) penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   initial begin
      repeat (3000) @(posedge pclk);
      fail_count++;
      give_verdict;
   end
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk("drive_enable", 0, drive_enable);
      ctl_i.power_up(40);
      chk("drive_enable", 3, drive_enable);
      for (int i = 0; i < 7; i++) rd_chk(lp4i_pkg::CMD_MODE_REG_READ, ma[i], md[i]);
      ctl_i.issue(lp4i_pkg::CMD_MODE_REG_WRITE, 6'h0b, 8'h00);
      ctl_i.issue(lp4i_pkg::CMD_CAL_START, 6'h00, 8'h00);
      repeat (lp4i_pkg::IMPEDANCE_CAL_CYCLES) @(posedge pclk);
      ctl_i.issue(lp4i_pkg::CMD_CAL_LATCH, 6'h00, 8'h00);
      repeat (8) @(posedge pclk);
      chk("cal_applied", 1, cal_applied);
      ctl_i.issue(lp4i_pkg::CMD_MODE_REG_WRITE, 6'h02, 8'h80);
      rd_chk(lp4i_pkg::CMD_MODE_REG_READ, 6'h02, 8'h80);
      ctl_i.issue(lp4i_pkg::CMD_MP_BUF_WRITE, 6'h00, 8'ha5);
      rd_chk(lp4i_pkg::CMD_MP_BUF_READ, 6'h00, 8'ha5);
      ctl_i.issue(lp4i_pkg::CMD_MODE_REG_WRITE, 6'h0f, 8'h3c);
      rd_chk(lp4i_pkg::CMD_MODE_REG_READ, 6'h0f, 8'h3c);
      apb(1'b1, 12'h040, 32'h1);
      chk("pslverr", 1, e);
      apb(1'b0, 12'h040, 32'h0);
      chk("pslverr", 1, e);
      apb(1'b0, lp4i_pkg::REG_STATUS, 32'h0);
      chk("status", {29'h0, lp4i_pkg::ST_READY}, q);
      apb(1'b0, lp4i_pkg::REG_ERRORS, 32'h0);
      chk("errors", 0, q);
      apb(1'b1, lp4i_pkg::REG_MR_LOW, 32'h0c);
      apb(1'b0, lp4i_pkg::REG_MR_HIGH, 32'h0);
      chk("mr view", 32'h4d, q);
      apb(1'b1, lp4i_pkg::REG_CONTROL, 32'h1);
      rd_chk(lp4i_pkg::CMD_MODE_REG_READ, 6'h0f, 8'h00);
      ctl_i.power_up(4);
      rd_chk(lp4i_pkg::CMD_MODE_REG_READ, 6'h02, 8'h00);
      give_verdict;
   end
endmodule
